// ### design/bank_pkg.sv
// shared types, timing figures and command decode for the bank rule logic
`default_nettype none
package bank_pkg;

  // clock and timing figures in nanoseconds, and the burst length
  localparam int CLK_NS   = 10;
  localparam int T_RP_NS  = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_WR_NS  = 15;
  localparam int T_RFC_NS = 80;
  localparam int T_MRD_NS = 10;
  localparam int BL       = 8;

  // least times round up to whole cycles; half burst and write latency in cycles
  localparam logic [4:0] RP_CYC  = 5'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] RCD_CYC = 5'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WR_CYC  = 5'((T_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] RFC_CYC = 5'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] MRD_CYC = 5'((T_MRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] HALF_BL = 5'(BL / 2);
  localparam logic [4:0] WR_LAT  = 5'h01;

  // counter loads: a state lasts load plus one cycles
  localparam logic [4:0] RP_LD    = RP_CYC - 5'h01;
  localparam logic [4:0] RCD_LD   = RCD_CYC - 5'h01;
  localparam logic [4:0] RFC_LD   = RFC_CYC - 5'h01;
  localparam logic [4:0] MRD_LD   = MRD_CYC - 5'h01;
  localparam logic [4:0] RD_LD    = HALF_BL - 5'h01;
  localparam logic [4:0] WR_LD    = WR_LAT + HALF_BL - 5'h01;
  localparam logic [4:0] RD_AP_LD = HALF_BL + RP_CYC - 5'h01;
  localparam logic [4:0] WR_AP_LD = WR_LAT + HALF_BL + WR_CYC + RP_CYC
                                    - 5'h01;

  typedef enum logic [3:0] {
    C_DESEL, C_NOP, C_ACT, C_READ, C_WRITE, C_BT, C_PRE, C_REF, C_LMR
  } cmd_type;

  typedef enum logic [2:0] {
    B_IDLE, B_ACTIVATING, B_ACTIVE, B_READ, B_WRITE, B_READ_AP,
    B_WRITE_AP, B_PRECHARGING
  } bank_state_type;

  typedef enum logic [2:0] {
    M_NORMAL, M_REFRESH, M_MODEREG, M_PALL, M_ACT_PD, M_PRE_PD,
    M_SELF_REF, M_DEEP_PD
  } dev_mode_type;

  // select, row, column and write strobes to a command
  function automatic cmd_type decode_cmd(input logic cs_n,
                                         input logic ras_n,
                                         input logic cas_n,
                                         input logic we_n);
    cmd_type c;
    c = C_DESEL;
    if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: c = C_NOP;
        3'h3: c = C_ACT;
        3'h5: c = C_READ;
        3'h4: c = C_WRITE;
        3'h2: c = C_PRE;
        3'h6: c = C_BT;
        3'h1: c = C_REF;
        3'h0: c = C_LMR;
      endcase
    end
    return c;
  endfunction

  function automatic logic is_quiet(input cmd_type c);
    return c == C_DESEL || c == C_NOP;
  endfunction

  // a row is open and takes column or precharge commands
  function automatic logic is_open(input bank_state_type s);
    return s == B_ACTIVE || s == B_READ || s == B_WRITE;
  endfunction

endpackage
`default_nettype wire

// ### design/bank_ctl_if.sv
// carrier between the command logic, bank trackers and burst tracker
`default_nettype none
interface bank_ctl_if;
  logic [3:0]               go_act;
  logic [3:0]               go_rd;
  logic [3:0]               go_wr;
  logic [3:0]               go_pre;
  logic [3:0]               go_stop;
  logic                     ap;
  bank_pkg::bank_state_type st [4];
  logic                     rd_start;
  logic                     bt;
  logic [1:0]               tgt;
  logic                     rd_busy;
  logic [1:0]               rd_bank;

  modport ctl (output go_act, go_rd, go_wr, go_pre, go_stop, ap,
               output rd_start, bt, tgt,
               input st, rd_busy, rd_bank);
  modport unit (input go_act, go_rd, go_wr, go_pre, go_stop, ap,
                output st);
  modport trk (input rd_start, bt, tgt, output rd_busy, rd_bank);
endinterface
`default_nettype wire

// ### design/bank_fsm.sv
// one bank's state with its own timing counter
`default_nettype none
module bank_fsm #(
  parameter int unsigned IDX = 0
) (
  input  wire logic clk,
  input  wire logic resetn,
  bank_ctl_if.unit  bus
);
  typedef struct packed {
    bank_pkg::bank_state_type st;
    logic [4:0]               cnt;
  } bank_reg_type;

  bank_reg_type s_r;
  bank_reg_type s_nxt;
  logic         open;

  assign open = bank_pkg::is_open(s_r.st);

  // timed states count down, then fall to their follow-on state
  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - 5'h01;
    unique case (s_r.st)
      bank_pkg::B_IDLE:
        if (bus.go_act[IDX]) s_nxt = '{bank_pkg::B_ACTIVATING,
                                       bank_pkg::RCD_LD};
      bank_pkg::B_ACTIVATING:
        if (s_r.cnt == '0) s_nxt.st = bank_pkg::B_ACTIVE;
      bank_pkg::B_ACTIVE: ;
      bank_pkg::B_READ, bank_pkg::B_WRITE:
        if (bus.go_stop[IDX] || s_r.cnt == '0) begin
          s_nxt.st = bank_pkg::B_ACTIVE;
        end
      bank_pkg::B_READ_AP, bank_pkg::B_WRITE_AP,
      bank_pkg::B_PRECHARGING:
        if (s_r.cnt == '0) s_nxt.st = bank_pkg::B_IDLE;
    endcase
    // auto precharge counts the access part first, then the row close
    if (open) begin
      if (bus.go_rd[IDX]) begin
        s_nxt = bus.ap ? '{bank_pkg::B_READ_AP, bank_pkg::RD_AP_LD}
                       : '{bank_pkg::B_READ, bank_pkg::RD_LD};
      end else if (bus.go_wr[IDX]) begin
        s_nxt = bus.ap ? '{bank_pkg::B_WRITE_AP, bank_pkg::WR_AP_LD}
                       : '{bank_pkg::B_WRITE, bank_pkg::WR_LD};
      end else if (bus.go_pre[IDX]) begin
        s_nxt = '{bank_pkg::B_PRECHARGING, bank_pkg::RP_LD};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign bus.st[IDX] = s_r.st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_read_ap_span: assert property (
    open && bus.go_rd[IDX] && bus.ap |=>
      (s_r.st == bank_pkg::B_READ_AP) [*6] ##1 s_r.st == bank_pkg::B_IDLE)
    else $error("read with auto precharge span wrong");

  a_write_ap_span: assert property (
    open && bus.go_wr[IDX] && bus.ap |=>
      (s_r.st == bank_pkg::B_WRITE_AP) [*8] ##1
      s_r.st == bank_pkg::B_WRITE_AP ##1 s_r.st == bank_pkg::B_IDLE)
    else $error("write with auto precharge span wrong");
endmodule
`default_nettype wire

// ### design/burst_track.sv
// remembers the most recent read burst and its remaining length
`default_nettype none
module burst_track (
  input  wire logic clk,
  input  wire logic resetn,
  bank_ctl_if.trk   bus
);
  typedef struct packed {
    logic [4:0] rd_left;
    logic [1:0] rd_bank;
  } trk_reg_type;

  trk_reg_type s_r;
  trk_reg_type s_nxt;

  // a new read replaces the old one; terminate ends whichever is latest
  always_comb begin
    s_nxt = s_r;
    if (s_r.rd_left != '0) s_nxt.rd_left = s_r.rd_left - 5'h01;
    if (bus.rd_start) begin
      s_nxt.rd_left = bank_pkg::HALF_BL;
      s_nxt.rd_bank = bus.tgt;
    end else if (bus.bt) begin
      s_nxt.rd_left = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign bus.rd_busy = s_r.rd_left != '0;
  assign bus.rd_bank = s_r.rd_bank;

  a_term_ends: assert property (
    @(posedge clk) disable iff (!resetn)
    bus.bt && !bus.rd_start |=> !bus.rd_busy ##1
      (bus.rd_busy == $past(bus.rd_start)))
    else $error("burst terminate left a read burst running");
endmodule
`default_nettype wire

// ### design/ddr_bank_rules.sv
// command legality, bank state and clock-enable modes of the sdram
//
// Summary of operation
// - auto-precharge bank holds that state until row close time, then idles
// - auto refresh holds refreshing for refresh cycle time, then all idle
// - mode register load holds access state for its delay, then all idle
// - precharge all holds its state for row close time, then all idle
// - burst terminate ends the latest read burst, on any bank
// - commands decode from select, row, column and write strobes
// - an idle bank never blocks commands to other banks
// - other banks take commands during auto precharge, no data clash
// - auto precharge starts after write recovery, or earliest read close
// - clock enable low twice keeps any power-down or self refresh
// - clock enable rising with deselect or nop leaves low power
// - clock enable falling with nop enters active or precharge power-down
// - clock enable falling with refresh and all idle enters self refresh
// - clock enable falling with terminate and all idle: deep power-down
// - deep power-down loses the stored data
`default_nettype none
module ddr_bank_rules (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   cke,
  input  wire logic                   cs_n,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic [1:0]             ba,
  input  wire logic                   ap_all,
  output var  bank_pkg::dev_mode_type   dev_mode,
  output var  bank_pkg::bank_state_type bank_state [4],
  output var  logic                   all_idle,
  output var  logic                   cmd_illegal,
  output var  logic                   data_lost
);

  typedef struct packed {
    bank_pkg::dev_mode_type mode;
    logic [4:0]             cnt;
    logic                   cke_prev;
    logic                   illegal;
    logic                   lost;
    logic                   idle;
  } top_reg_type;

  top_reg_type              s_r;
  top_reg_type              s_nxt;
  bank_pkg::cmd_type        cmd;
  bank_pkg::bank_state_type tgt_st;
  logic                     quiet;
  logic                     run;
  logic                     timed;
  logic                     low_pwr;
  logic                     idle_now;
  logic                     pall_bad;
  logic [3:0]               open_vec;
  logic                     take_ar;
  logic                     take_lmr;
  logic                     take_pall;

  bank_ctl_if bus ();

  // low power modes share one exit and hold rule
  function automatic logic is_low_pwr(input bank_pkg::dev_mode_type m);
    return m == bank_pkg::M_ACT_PD || m == bank_pkg::M_PRE_PD ||
           m == bank_pkg::M_SELF_REF || m == bank_pkg::M_DEEP_PD;
  endfunction

  // command pins are on this clock already, so no synchroniser
  assign cmd     = bank_pkg::decode_cmd(cs_n, ras_n, cas_n, we_n);
  assign quiet   = bank_pkg::is_quiet(cmd);
  assign tgt_st  = bus.st[ba];
  assign low_pwr = is_low_pwr(s_r.mode);
  assign timed   = s_r.mode == bank_pkg::M_REFRESH ||
                   s_r.mode == bank_pkg::M_MODEREG ||
                   s_r.mode == bank_pkg::M_PALL;

  // commands execute only with clock enable high on both edges
  assign run = s_r.mode == bank_pkg::M_NORMAL && s_r.cke_prev && cke;

  assign take_ar   = run && cmd == bank_pkg::C_REF && idle_now;
  assign take_lmr  = run && cmd == bank_pkg::C_LMR && idle_now;
  assign take_pall = run && cmd == bank_pkg::C_PRE && ap_all && !pall_bad;

  assign bus.ap  = ap_all;
  assign bus.tgt = ba;

  // bank summary: all idle, open rows, banks that forbid precharge
  always_comb begin
    idle_now = 1'b1;
    pall_bad = 1'b0;
    open_vec = '0;
    for (int i = 0; i < 4; i++) begin
      if (bus.st[i] != bank_pkg::B_IDLE) idle_now = 1'b0;
      open_vec[i] = bank_pkg::is_open(bus.st[i]);
      if (bus.st[i] == bank_pkg::B_ACTIVATING ||
          bus.st[i] == bank_pkg::B_READ_AP ||
          bus.st[i] == bank_pkg::B_WRITE_AP) begin
        pall_bad = 1'b1;
      end
    end
  end

  // device mode, command dispatch and legality in one place
  always_comb begin
    s_nxt          = s_r;
    s_nxt.cke_prev = cke;
    s_nxt.illegal  = 1'b0;
    s_nxt.idle     = idle_now;
    bus.go_act     = '0;
    bus.go_rd      = '0;
    bus.go_wr      = '0;
    bus.go_pre     = '0;
    bus.go_stop    = '0;
    bus.rd_start   = 1'b0;
    bus.bt         = 1'b0;
    if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - 5'h01;

    unique case (s_r.mode)
      bank_pkg::M_REFRESH, bank_pkg::M_MODEREG, bank_pkg::M_PALL: begin
        // executable commands here are flagged and dropped
        if (!quiet) s_nxt.illegal = 1'b1;
        if (s_r.cnt == '0) begin
          s_nxt.mode = bank_pkg::M_NORMAL;
        end
      end

      bank_pkg::M_ACT_PD, bank_pkg::M_PRE_PD,
      bank_pkg::M_SELF_REF, bank_pkg::M_DEEP_PD: begin
        // clock enable still low: hold, command ignored
        if (cke) begin
          if (quiet) s_nxt.mode = bank_pkg::M_NORMAL;
          else s_nxt.illegal = 1'b1;
        end
      end

      bank_pkg::M_NORMAL: begin
        if (s_r.cke_prev && !cke) begin
          // falling clock enable: the command picks the low power mode
          if (quiet) begin
            s_nxt.mode = idle_now ? bank_pkg::M_PRE_PD
                                  : bank_pkg::M_ACT_PD;
          end else if (cmd == bank_pkg::C_REF && idle_now) begin
            s_nxt.mode = bank_pkg::M_SELF_REF;
          end else if (cmd == bank_pkg::C_BT && idle_now) begin
            s_nxt.mode = bank_pkg::M_DEEP_PD;
            s_nxt.lost = 1'b1;
          end else begin
            s_nxt.illegal = 1'b1;
          end
        end else if (run) begin
          unique case (cmd)
            bank_pkg::C_DESEL, bank_pkg::C_NOP: ;
            bank_pkg::C_ACT: begin
              // per-bank check only; other banks never block it
              if (tgt_st == bank_pkg::B_IDLE) bus.go_act[ba] = 1'b1;
              else s_nxt.illegal = 1'b1;
            end
            bank_pkg::C_READ: begin
              if (open_vec[ba]) begin
                bus.go_rd[ba] = 1'b1;
                bus.rd_start  = 1'b1;
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
            bank_pkg::C_WRITE: begin
              // a live read burst would clash on the data bus
              if (open_vec[ba] && !bus.rd_busy) begin
                bus.go_wr[ba] = 1'b1;
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
            bank_pkg::C_PRE: begin
              if (ap_all) begin
                if (take_pall) begin
                  bus.go_pre = open_vec;
                  s_nxt.mode = bank_pkg::M_PALL;
                  s_nxt.cnt  = bank_pkg::RP_LD;
                end else begin
                  s_nxt.illegal = 1'b1;
                end
              end else if (open_vec[ba]) begin
                bus.go_pre[ba] = 1'b1;
              end else if (tgt_st != bank_pkg::B_IDLE &&
                           tgt_st != bank_pkg::B_PRECHARGING) begin
                s_nxt.illegal = 1'b1;
              end
            end
            bank_pkg::C_BT: begin
              // not decoded per bank: the tracker names the bank
              if (bus.rd_busy) begin
                bus.bt                   = 1'b1;
                bus.go_stop[bus.rd_bank] = 1'b1;
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
            bank_pkg::C_REF: begin
              if (take_ar) begin
                s_nxt.mode = bank_pkg::M_REFRESH;
                s_nxt.cnt  = bank_pkg::RFC_LD;
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
            bank_pkg::C_LMR: begin
              if (take_lmr) begin
                s_nxt.mode = bank_pkg::M_MODEREG;
                s_nxt.cnt  = bank_pkg::MRD_LD;
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_r <= '0;
    else s_r <= s_nxt;
  end

  // four identical bank trackers
  for (genvar g = 0; g < 4; g++) begin : g_bank
    bank_fsm #(
      .IDX (g)
    ) u_bank (
      .clk    (clk),
      .resetn (resetn),
      .bus    (bus)
    );
    assign bank_state[g] = bus.st[g];
  end

  burst_track u_trk (
    .clk    (clk),
    .resetn (resetn),
    .bus    (bus)
  );

  // outputs taken from the state register
  assign dev_mode    = s_r.mode;
  assign all_idle    = s_r.idle;
  assign cmd_illegal = s_r.illegal;
  assign data_lost   = s_r.lost;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_refresh_span: assert property (
    take_ar |=> (s_r.mode == bank_pkg::M_REFRESH) [*8] ##1
                (s_r.mode == bank_pkg::M_NORMAL && idle_now))
    else $error("refresh state length wrong");

  a_mode_access: assert property (
    take_lmr |=> s_r.mode == bank_pkg::M_MODEREG ##1
                 s_r.mode == bank_pkg::M_NORMAL)
    else $error("mode register access length wrong");

  a_pall_span: assert property (
    take_pall |=> (s_r.mode == bank_pkg::M_PALL) [*2] ##1
                  (s_r.mode == bank_pkg::M_NORMAL && idle_now))
    else $error("precharge all length wrong");

  a_timed_guard: assert property (
    timed && !quiet |=> cmd_illegal)
    else $error("command in timed state not flagged");

  a_low_hold: assert property (
    low_pwr && !cke |=> $stable(s_r.mode))
    else $error("low power mode left with clock enable low");

  a_low_exit: assert property (
    low_pwr && cke && quiet |=> s_r.mode == bank_pkg::M_NORMAL)
    else $error("low power exit missed");

  a_pd_entry: assert property (
    s_r.mode == bank_pkg::M_NORMAL && s_r.cke_prev && !cke && quiet
    |=> s_r.mode == ($past(idle_now) ? bank_pkg::M_PRE_PD
                                     : bank_pkg::M_ACT_PD))
    else $error("power-down entry picked wrong mode");

  a_self_ref_in: assert property (
    s_r.mode == bank_pkg::M_NORMAL && s_r.cke_prev && !cke &&
    cmd == bank_pkg::C_REF && idle_now
    |=> s_r.mode == bank_pkg::M_SELF_REF)
    else $error("self refresh entry missed");

  a_deep_in: assert property (
    s_r.mode == bank_pkg::M_NORMAL && s_r.cke_prev && !cke &&
    cmd == bank_pkg::C_BT && idle_now
    |=> s_r.mode == bank_pkg::M_DEEP_PD && data_lost)
    else $error("deep power-down entry missed");

  a_write_clash: assert property (
    run && cmd == bank_pkg::C_WRITE && bus.rd_busy
    |=> cmd_illegal && !$past(bus.go_wr[ba]))
    else $error("write during read burst accepted");

  a_other_bank: assert property (
    run && cmd == bank_pkg::C_ACT && tgt_st == bank_pkg::B_IDLE
    |=> bus.st[$past(ba)] == bank_pkg::B_ACTIVATING && !cmd_illegal)
    else $error("activate to idle bank refused");

endmodule
`default_nettype wire

// ### bench/ctl_model.sv
// controller model: turns requested commands into command bus levels
`default_nettype none
module ctl_model (
  input  wire bank_pkg::cmd_type      rq_c,
  input  wire logic [1:0]             rq_b,
  input  wire logic                   rq_a,
  input  wire logic                   rq_k,
  input  wire logic                   allow_bad,
  input  wire bank_pkg::dev_mode_type dev_mode,
  output var  logic                   cke,
  output var  logic                   cs_n,
  output var  logic                   ras_n,
  output var  logic                   cas_n,
  output var  logic                   we_n,
  output var  logic [1:0]             ba,
  output var  logic                   ap_all
);
  timeunit 1ns;
  timeprecision 1ps;
  bank_pkg::cmd_type c;
  logic              busy;
  // timed device states get only nop unless a test asks for a violation
  assign busy = dev_mode == bank_pkg::M_REFRESH ||
                dev_mode == bank_pkg::M_MODEREG ||
                dev_mode == bank_pkg::M_PALL;
  // strobe encoding, combinational so levels change just after the edge
  always_comb begin
    c = (busy && !allow_bad) ? bank_pkg::C_NOP : rq_c;
    case (c)
      bank_pkg::C_DESEL: {cs_n, ras_n, cas_n, we_n} = 4'hF;
      bank_pkg::C_ACT:   {cs_n, ras_n, cas_n, we_n} = 4'h3;
      bank_pkg::C_READ:  {cs_n, ras_n, cas_n, we_n} = 4'h5;
      bank_pkg::C_WRITE: {cs_n, ras_n, cas_n, we_n} = 4'h4;
      bank_pkg::C_BT:    {cs_n, ras_n, cas_n, we_n} = 4'h6;
      bank_pkg::C_PRE:   {cs_n, ras_n, cas_n, we_n} = 4'h2;
      bank_pkg::C_REF:   {cs_n, ras_n, cas_n, we_n} = 4'h1;
      bank_pkg::C_LMR:   {cs_n, ras_n, cas_n, we_n} = 4'h0;
      default:           {cs_n, ras_n, cas_n, we_n} = 4'h7;
    endcase
  end
  assign ba = rq_b;
  assign ap_all = rq_a;
  assign cke = rq_k;
endmodule
`default_nettype wire

// ### bench/ddr_bank_rules_tb.sv
// self-checking bench for bank states and clock-enable modes
`default_nettype none
module ddr_bank_rules_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    bank_pkg::cmd_type        c;
    logic [1:0]               b;
    logic                     a;
    logic [3:0]               d;
    logic                     cb;
    bank_pkg::bank_state_type es;
    bank_pkg::dev_mode_type   em;
  } row_type;
  localparam int NR = 15;
  // rows wait out bank timers, except the bank 2 activate and write during bank 1's read auto precharge
  // command, bank, ap, cycles after taking, check bank, bank, mode
  localparam row_type ROWS [NR] = '{
    '{bank_pkg::C_ACT, 2'h1, 1'h0, 4'h2, 1'h1, bank_pkg::B_ACTIVATING,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_DESEL, 2'h1, 1'h0, 4'h0, 1'h1, bank_pkg::B_ACTIVE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_READ, 2'h1, 1'h1, 4'h1, 1'h1, bank_pkg::B_READ_AP,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_ACT, 2'h2, 1'h0, 4'h2, 1'h1, bank_pkg::B_ACTIVATING,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_NOP, 2'h1, 1'h0, 4'h0, 1'h1, bank_pkg::B_READ_AP,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_WRITE, 2'h2, 1'h1, 4'h9, 1'h1, bank_pkg::B_WRITE_AP,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_NOP, 2'h2, 1'h0, 4'h0, 1'h1, bank_pkg::B_IDLE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_NOP, 2'h1, 1'h0, 4'h0, 1'h1, bank_pkg::B_IDLE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_REF, 2'h0, 1'h0, 4'h8, 1'h0, bank_pkg::B_IDLE,
      bank_pkg::M_REFRESH},
    '{bank_pkg::C_NOP, 2'h0, 1'h0, 4'h0, 1'h1, bank_pkg::B_IDLE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_LMR, 2'h0, 1'h0, 4'h1, 1'h0, bank_pkg::B_IDLE,
      bank_pkg::M_MODEREG},
    '{bank_pkg::C_NOP, 2'h0, 1'h0, 4'h0, 1'h0, bank_pkg::B_IDLE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_ACT, 2'h0, 1'h0, 4'h3, 1'h1, bank_pkg::B_ACTIVE,
      bank_pkg::M_NORMAL},
    '{bank_pkg::C_PRE, 2'h0, 1'h1, 4'h2, 1'h0, bank_pkg::B_IDLE,
      bank_pkg::M_PALL},
    '{bank_pkg::C_NOP, 2'h0, 1'h0, 4'h0, 1'h1, bank_pkg::B_IDLE,
      bank_pkg::M_NORMAL}
  };
  logic                     clk = 1'h0;
  logic                     resetn = 1'h0;
  bank_pkg::cmd_type        rq_c = bank_pkg::C_NOP;
  logic [1:0]               rq_b = 2'h0;
  logic                     rq_a = 1'h0;
  logic                     rq_k = 1'h1;
  logic                     allow_bad = 1'h0;
  logic                     cke, cs_n, ras_n, cas_n, we_n, ap_all;
  logic [1:0]               ba;
  bank_pkg::dev_mode_type   dev_mode;
  bank_pkg::bank_state_type bank_state [4];
  logic                     all_idle, cmd_illegal, data_lost;
  int                       n_mismatch = 0;
  int                       n_checks = 0;
  int                       cycles = 0;
  // free-running clock, so it always toggles during exit delays
  always #5 clk = ~clk;
  ctl_model ctl_model_inst (.rq_c(rq_c), .rq_b(rq_b), .rq_a(rq_a),
    .rq_k(rq_k), .allow_bad(allow_bad), .dev_mode(dev_mode), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .ap_all(ap_all));
  ddr_bank_rules ddr_bank_rules_inst (.clk(clk), .resetn(resetn),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .ap_all(ap_all), .dev_mode(dev_mode),
    .bank_state(bank_state), .all_idle(all_idle),
    .cmd_illegal(cmd_illegal), .data_lost(data_lost));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [2:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // one request per rising edge; held until the next call
  task automatic cyc(input bank_pkg::cmd_type c, input logic [1:0] b,
                     input logic a, k);
    @(posedge clk);
    rq_c <= c;
    rq_b <= b;
    rq_a <= a;
    rq_k <= k;
  endtask
  // command, then d nops, then look in cycle d after the taking edge
  task automatic run(input bank_pkg::cmd_type c, input logic [1:0] b,
                     input logic a, k, input int d);
    cyc(c, b, a, k);
    repeat (d) cyc(bank_pkg::C_NOP, 2'h0, 1'h0, k);
    @(negedge clk);
  endtask
  // enter a low power mode, hold it under a command, leave with nop
  task automatic lowp(input bank_pkg::cmd_type c,
                      input bank_pkg::dev_mode_type em);
    run(c, 2'h0, 1'h0, 1'h0, 1);
    chk("enter", dev_mode, em);
    run(bank_pkg::C_ACT, 2'h1, 1'h0, 1'h0, 3);
    chk("hold", dev_mode, em);
    run(bank_pkg::C_NOP, 2'h0, 1'h0, 1'h1, 1); // nop during exit
    chk("exit", dev_mode, bank_pkg::M_NORMAL);
  endtask
  // hang guard, far above the 124 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NR; i++) begin
      run(ROWS[i].c, ROWS[i].b, ROWS[i].a, 1'h1, int'(ROWS[i].d));
      chk("mode", dev_mode, ROWS[i].em);
      if (ROWS[i].cb) begin
        chk("bank", bank_state[ROWS[i].b], ROWS[i].es);
      end
    end
    // refusals and burst terminate
    run(bank_pkg::C_READ, 2'h0, 1'h0, 1'h1, 1);
    chk("bad read", cmd_illegal, 3'h1);
    chk("idle kept", bank_state[0], bank_pkg::B_IDLE);
    run(bank_pkg::C_BT, 2'h0, 1'h0, 1'h1, 1);
    chk("bad stop", cmd_illegal, 3'h1);
    run(bank_pkg::C_ACT, 2'h0, 1'h0, 1'h1, 3);
    run(bank_pkg::C_READ, 2'h0, 1'h0, 1'h1, 0);
    run(bank_pkg::C_WRITE, 2'h0, 1'h0, 1'h1, 1);
    chk("bad write", cmd_illegal, 3'h1);
    run(bank_pkg::C_BT, 2'h0, 1'h0, 1'h1, 1);
    chk("stopped", bank_state[0], bank_pkg::B_ACTIVE);
    // power-down with a row open, then with all banks closed
    lowp(bank_pkg::C_NOP, bank_pkg::M_ACT_PD);
    run(bank_pkg::C_PRE, 2'h0, 1'h0, 1'h1, 4);
    lowp(bank_pkg::C_NOP, bank_pkg::M_PRE_PD);
    // executable command while refreshing is flagged
    run(bank_pkg::C_REF, 2'h0, 1'h0, 1'h1, 1); // all banks idle
    @(posedge clk) allow_bad <= 1'h1;
    run(bank_pkg::C_ACT, 2'h1, 1'h0, 1'h1, 1);
    chk("busy cmd", cmd_illegal, 3'h1);
    chk("busy mode", dev_mode, bank_pkg::M_REFRESH);
    @(posedge clk) allow_bad <= 1'h0;
    run(bank_pkg::C_NOP, 2'h0, 1'h0, 1'h1, 9);
    lowp(bank_pkg::C_REF, bank_pkg::M_SELF_REF);
    lowp(bank_pkg::C_BT, bank_pkg::M_DEEP_PD);
    chk("lost", data_lost, 3'h1);
    // full restart after deep power-down, checked in mid-run reset
    @(posedge clk) resetn <= 1'h0;
    @(negedge clk);
    chk("rst mode", dev_mode, bank_pkg::M_NORMAL);
    chk("rst lost", data_lost, 3'h0);
    chk("rst flag", cmd_illegal, 3'h0);
    chk("rst idle", all_idle, 3'h0);
    for (int j = 0; j < 4; j++) begin
      chk("rst bank", bank_state[j], bank_pkg::B_IDLE);
    end
    // release with a command already up: dropped, clock enable not yet seen
    cyc(bank_pkg::C_ACT, 2'h3, 1'h0, 1'h1);
    resetn <= 1'h1;
    run(bank_pkg::C_NOP, 2'h0, 1'h0, 1'h1, 0);
    chk("early cmd", bank_state[3], bank_pkg::B_IDLE);
    chk("early flag", cmd_illegal, 3'h0);
    chk("idle seen", all_idle, 3'h1);
    run(bank_pkg::C_ACT, 2'h3, 1'h0, 1'h1, 1);
    chk("late cmd", bank_state[3], bank_pkg::B_ACTIVATING);
    // precharge to a bank still activating is refused
    run(bank_pkg::C_PRE, 2'h3, 1'h0, 1'h1, 1);
    chk("bad pre", cmd_illegal, 3'h1);
    complete_run;
  end
endmodule
`default_nettype wire
